// [cmsc_defs.svh]
// timing counts, reset values and field codes for the clock mode and stop controller
// assumes a 100 MHz system clock; included by bare name
`ifndef CMSC_DEFS_SVH
`define CMSC_DEFS_SVH

`define CMSC_CLK_PERIOD_NS   10
`define CMSC_LATENCY_NS      160
`define CMSC_LATENCY_CYC     ((`CMSC_LATENCY_NS + `CMSC_CLK_PERIOD_NS - 1) / `CMSC_CLK_PERIOD_NS)
`define CMSC_POST_DIV_RST    5'h03
`define CMSC_VCO_RST_MHZ     8'h32
`define CMSC_RATE_LONGEST    3'h7
`define CMSC_RATE_OFF        3'h0

`endif

// [cmsc_pkg.sv]
// types shared by the clock mode and stop controller files
// assumes nothing of its surroundings
package cmsc_pkg;

   typedef enum logic [2:0] {
      CMSC_RUN         = 3'b000,
      CMSC_ENTER_LAT   = 3'b001,
      CMSC_FULL_STOP   = 3'b010,
      CMSC_PSEUDO_STOP = 3'b011,
      CMSC_EXIT_LAT    = 3'b100
   } cmsc_state_t;

   typedef enum logic [1:0] {
      CMSC_PLL_INT_REF = 2'b00,
      CMSC_PLL_EXT_REF = 2'b01,
      CMSC_PLL_BYPASS  = 2'b10
   } cmsc_clk_mode_t;

endpackage

// [cmsc_clk_switch.sv]
// glitch-free selection between two clock-enable pulse trains
// assumes both pulse trains are synchronous one-cycle pulses on clk
`timescale 1ns/100ps
module cmsc_clk_switch
   import cmsc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sel_a,
   input  wire logic a_en,
   input  wire logic b_en,
   output logic      out_en,
   output logic      cur_a
);

   logic pending;

   assign pending = (sel_a != cur_a);

   // RL23 no shortened phases
   // while a change is pending nothing passes; the first pulse of the new
   // source only re-times the switch, so every output period is whole
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_a <= 1'b1;
      end else if (pending && (sel_a ? a_en : b_en)) begin
         cur_a <= sel_a;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_en <= 1'b0;
      end else begin
         out_en <= !pending && (cur_a ? a_en : b_en);
      end
   end

endmodule // cmsc_clk_switch

// [cmsc_ctrl.sv]
// clock mode, stop mode and debug freeze control of a clock, reset and power unit
// assumes every source clock arrives as a one-cycle enable pulse on clk and that
// software control bits are plain levels synchronous to clk
`timescale 1ns/100ps
`include "cmsc_defs.svh"

// Functional notes
// RL1 - reset enters PLL mode on internal reference
// RL2 - reset post divider 0x03, bus 6.25MHz
// RL3 - internal-reference mode uses 1 MHz reference
// RL4 - software enables oscillator, waits up and lock
// RL5 - bypass: bus from crystal, PLL stays on
// RL6 - software waits oscillator up, then clears select
// RL7 - wait mode identical to run mode
// RL8 - stop turns off PLL, reference, bus clock
// RL9 - stop: reduced regulator, low-volt monitors off
// RL10 - pseudo stop needs both bits, else full
// RL11 - full stop, source low: timers halt
// RL12 - full stop wake: PLL bus, reference timers
// RL13 - RC watchdog runs or freezes by stop-disable
// RL14 - RC watchdog frozen: latency on entry, exit
// RL15 - full stop, source high: periodic halts
// RL16 - pseudo, source low: both need enables
// RL17 - pseudo, source high: periodic needs enable
// RL18 - pseudo stop leaves select bits unchanged
// RL19 - software waits startup time before pseudo
// RL20 - debug freezes timers when freeze set
// RL21 - debug can force longest watchdog rate
// RL22 - reset pin async in, open-drain out
// RL23 - bus clock source switch is glitch-free
module cmsc_ctrl
   import cmsc_pkg::*;
#(
   parameter int LATENCY_CYC = `CMSC_LATENCY_CYC
)
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       rst_pin_in,
   output logic            rst_pin_out,
   output logic            rst_pin_oe,
   input  wire logic       int_reset_req,
   input  wire logic       stop_req,
   input  wire logic       wake_req,
   input  wire logic       wait_req,
   input  wire logic       debug_halt_state,
   input  wire logic       pll_select,
   input  wire logic       osc_enable,
   input  wire logic       pseudo_stop_sel,
   input  wire logic       wdog_src_sel_hi,
   input  wire logic       wdog_src_sel_lo,
   input  wire logic       periodic_src_sel,
   input  wire logic       wdog_stop_disable,
   input  wire logic       wdog_pseudo_en,
   input  wire logic       periodic_pseudo_en,
   input  wire logic       debug_freeze_timers,
   input  wire logic [2:0] wdog_rate,
   input  wire logic       osc_up_status,
   input  wire logic       pll_lock,
   input  wire logic       pll_out_clk,
   input  wire logic       crystal_clk,
   input  wire logic       internal_ref_clk,
   input  wire logic       rc_clk,
   output logic            bus_clk_en,
   output cmsc_clk_mode_t  clk_mode,
   output cmsc_state_t     stop_state,
   output logic            pll_on,
   output logic            internal_ref_osc,
   output logic            osc_on,
   output logic            pll_ref_ext,
   output logic [4:0]      pll_post_div,
   output logic [7:0]      vco_target_mhz,
   output logic            regulator_reduced_perf,
   output logic            low_volt_en,
   output logic            autonomous_periodic_timer,
   output logic            wdog_tick,
   output logic            periodic_tick,
   output logic            latency_busy,
   output logic [2:0]      wdog_rate_eff
);

   cmsc_state_t state_r;
   cmsc_state_t state_nxt;
   logic        rst_n;
   logic [15:0] lat_cnt_r;
   logic        full_r;
   logic        force_pll_r;
   logic        force_ref_r;
   logic        pll_sel_eff;
   logic        wdog_lo_eff;
   logic        per_sel_eff;
   logic        want_pseudo;
   logic        rc_frozen;
   logic        in_stop;
   logic        sw_bus_en;
   logic        sw_cur_pll;
   logic        wdog_nxt;
   logic        per_nxt;
   logic        frz;

   // RL22 pin resets asynchronously
   assign rst_n = arst_n & rst_pin_in;

   // RL10 pseudo versus full
   assign want_pseudo = pseudo_stop_sel && osc_enable;
   // RL14 latency condition
   assign rc_frozen   = wdog_src_sel_hi && wdog_stop_disable;
   assign in_stop     = (state_r == CMSC_FULL_STOP) || (state_r == CMSC_PSEUDO_STOP);

   // RL12 forced sources after wake
   assign pll_sel_eff = pll_select || force_pll_r;
   assign wdog_lo_eff = wdog_src_sel_lo && !force_ref_r;
   assign per_sel_eff = periodic_src_sel && !force_ref_r;

   // RL7 wait needs no state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CMSC_RUN: begin
            if (stop_req) begin
               state_nxt = rc_frozen ? CMSC_ENTER_LAT
                         : (want_pseudo ? CMSC_PSEUDO_STOP : CMSC_FULL_STOP);
            end
         end
         CMSC_ENTER_LAT: begin
            if (lat_cnt_r == 16'(LATENCY_CYC - 1)) begin
               state_nxt = full_r ? CMSC_FULL_STOP : CMSC_PSEUDO_STOP;
            end
         end
         CMSC_FULL_STOP, CMSC_PSEUDO_STOP: begin
            if (wake_req) begin
               state_nxt = rc_frozen ? CMSC_EXIT_LAT : CMSC_RUN;
            end
         end
         CMSC_EXIT_LAT: begin
            if (lat_cnt_r == 16'(LATENCY_CYC - 1)) begin
               state_nxt = CMSC_RUN;
            end
         end
         default: state_nxt = CMSC_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= CMSC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // RL10 stop kind fixed at entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full_r <= 1'b0;
      end else if (state_r == CMSC_RUN && stop_req) begin
         full_r <= !want_pseudo;
      end
   end

   // RL14 latency counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_cnt_r <= 16'h0000;
      end else if (state_r != state_nxt) begin
         lat_cnt_r <= 16'h0000;
      end else if (state_r == CMSC_ENTER_LAT || state_r == CMSC_EXIT_LAT) begin
         lat_cnt_r <= lat_cnt_r + 16'h0001;
      end
   end

   // RL12 force held until software writes agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         force_pll_r <= 1'b0;
         force_ref_r <= 1'b0;
      end else if (state_r == CMSC_FULL_STOP && wake_req) begin
         force_pll_r <= 1'b1;
         force_ref_r <= 1'b1;
      end else begin
         if (pll_select) begin
            force_pll_r <= 1'b0;
         end
         if (!wdog_src_sel_lo && !periodic_src_sel) begin
            force_ref_r <= 1'b0;
         end
      end
   end

   // RL18 pseudo stop touches no select
   // RL23 glitch-free bus source switch
   cmsc_clk_switch u_switch (
      .clk    (clk),
      .rst_n  (rst_n),
      .sel_a  (pll_sel_eff),
      .a_en   (pll_out_clk),
      .b_en   (crystal_clk),
      .out_en (sw_bus_en),
      .cur_a  (sw_cur_pll)
   );

   // RL8 bus clock stopped in stop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_clk_en <= 1'b0;
      end else begin
         bus_clk_en <= sw_bus_en && (state_nxt == CMSC_RUN) && (state_r == CMSC_RUN);
      end
   end

   // RL1 RL3 RL5 mode report
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_mode    <= CMSC_PLL_INT_REF;
         pll_ref_ext <= 1'b0;
      end else begin
         pll_ref_ext <= osc_enable && osc_up_status;
         if (!sw_cur_pll) begin
            clk_mode <= CMSC_PLL_BYPASS;
         end else if (osc_enable && osc_up_status && pll_lock) begin
            clk_mode <= CMSC_PLL_EXT_REF;
         end else begin
            clk_mode <= CMSC_PLL_INT_REF;
         end
      end
   end

   // RL2 reset divider setting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_post_div   <= `CMSC_POST_DIV_RST;
         vco_target_mhz <= `CMSC_VCO_RST_MHZ;
      end else begin
         pll_post_div   <= pll_post_div;
         vco_target_mhz <= vco_target_mhz;
      end
   end

   // RL8 RL9 RL10 analog enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_state                <= CMSC_RUN;
         pll_on                    <= 1'b1;
         internal_ref_osc          <= 1'b1;
         osc_on                    <= 1'b0;
         regulator_reduced_perf    <= 1'b0;
         low_volt_en               <= 1'b1;
         autonomous_periodic_timer <= 1'b1;
         latency_busy              <= 1'b0;
      end else begin
         stop_state                <= state_nxt;
         pll_on                    <= !(state_nxt == CMSC_FULL_STOP
                                        || state_nxt == CMSC_PSEUDO_STOP);
         internal_ref_osc          <= !(state_nxt == CMSC_FULL_STOP
                                        || state_nxt == CMSC_PSEUDO_STOP);
         osc_on                    <= osc_enable && (state_nxt != CMSC_FULL_STOP);
         regulator_reduced_perf    <= (state_nxt == CMSC_FULL_STOP
                                        || state_nxt == CMSC_PSEUDO_STOP);
         low_volt_en               <= !(state_nxt == CMSC_FULL_STOP
                                        || state_nxt == CMSC_PSEUDO_STOP);
         autonomous_periodic_timer <= 1'b1;
         latency_busy              <= (state_nxt == CMSC_ENTER_LAT
                                        || state_nxt == CMSC_EXIT_LAT);
      end
   end

   // RL20 debug freeze
   assign frz = debug_halt_state && debug_freeze_timers;

   // RL11 RL13 RL15 RL16 RL17 timer clock gating
   always_comb begin
      wdog_nxt = 1'b0;
      per_nxt  = 1'b0;
      case (state_r)
         CMSC_RUN: begin
            wdog_nxt = wdog_src_sel_hi ? rc_clk
                     : (wdog_lo_eff ? crystal_clk : internal_ref_clk);
            per_nxt  = per_sel_eff ? crystal_clk : internal_ref_clk;
         end
         CMSC_FULL_STOP: begin
            wdog_nxt = wdog_src_sel_hi && !wdog_stop_disable && rc_clk;
            per_nxt  = 1'b0;
         end
         CMSC_PSEUDO_STOP: begin
            if (wdog_src_sel_hi) begin
               wdog_nxt = !wdog_stop_disable && rc_clk;
               per_nxt  = periodic_pseudo_en && crystal_clk;
            end else begin
               wdog_nxt = wdog_pseudo_en && periodic_pseudo_en && crystal_clk;
               per_nxt  = wdog_pseudo_en && periodic_pseudo_en && crystal_clk;
            end
         end
         // latency states and anything else keep both timers still
         default: wdog_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_tick     <= 1'b0;
         periodic_tick <= 1'b0;
      end else begin
         wdog_tick     <= wdog_nxt && !frz;
         periodic_tick <= per_nxt && !frz;
      end
   end

   // RL21 longest rate in debug when freeze off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_rate_eff <= `CMSC_RATE_OFF;
      end else if (debug_halt_state && !debug_freeze_timers
                   && wdog_rate != `CMSC_RATE_OFF) begin
         wdog_rate_eff <= `CMSC_RATE_LONGEST;
      end else begin
         wdog_rate_eff <= wdog_rate;
      end
   end

   // RL22 open-drain reset drive
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pin_out <= 1'b0;
         rst_pin_oe  <= 1'b0;
      end else begin
         rst_pin_out <= 1'b0;
         rst_pin_oe  <= int_reset_req;
      end
   end

   a_stop_pll_off: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      in_stop |-> !pll_on && !internal_ref_osc && !bus_clk_en)
      else $error("pll or bus clock active in stop");

   a_stop_regulator: assert property (@(posedge clk) disable iff (!rst_n) // RL9
      in_stop |-> regulator_reduced_perf && !low_volt_en)
      else $error("regulator not reduced in stop");

   a_wait_run: assert property (@(posedge clk) disable iff (!rst_n) // RL7
      (state_r == CMSC_RUN && wait_req && !stop_req) |=> state_r == CMSC_RUN && pll_on)
      else $error("wait changed run behaviour");

   a_stop_kind: assert property (@(posedge clk) disable iff (!rst_n) // RL10
      (state_r == CMSC_RUN && stop_req && !rc_frozen)
      |=> (state_r == (want_pseudo ? CMSC_PSEUDO_STOP : CMSC_FULL_STOP)) or
          (state_r == (($past(want_pseudo)) ? CMSC_PSEUDO_STOP : CMSC_FULL_STOP)))
      else $error("wrong stop kind");

   a_full_halt: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      (state_r == CMSC_FULL_STOP && !wdog_src_sel_hi) |=> !wdog_tick && !periodic_tick)
      else $error("timer ticked in full stop");

   a_full_osc_off: assert property (@(posedge clk) disable iff (!rst_n) // RL10
      (state_nxt == CMSC_FULL_STOP) |=> !osc_on)
      else $error("oscillator on in full stop");

   a_latency_len: assert property (@(posedge clk) disable iff (!rst_n) // RL14
      (state_r == CMSC_RUN && stop_req && rc_frozen)
      |=> (state_r == CMSC_ENTER_LAT)[*2])
      else $error("latency period too short");

   a_wake_pll: assert property (@(posedge clk) disable iff (!rst_n) // RL12
      (state_r == CMSC_FULL_STOP && wake_req) |=> force_pll_r && force_ref_r)
      else $error("full stop wake not on pll");

   a_debug_freeze: assert property (@(posedge clk) disable iff (!rst_n) // RL20
      frz |=> !wdog_tick && !periodic_tick)
      else $error("timer ticked while frozen");

   a_debug_rate: assert property (@(posedge clk) disable iff (!rst_n) // RL21
      (debug_halt_state && !debug_freeze_timers && wdog_rate != 3'h0)
      |=> wdog_rate_eff == 3'h7)
      else $error("debug rate not forced");

   a_reset_drive: assert property (@(posedge clk) disable iff (!arst_n) // RL22
      int_reset_req |=> rst_pin_oe && !rst_pin_out)
      else $error("reset pin not driven low");

   c_pseudo_stop: cover property (@(posedge clk) disable iff (!rst_n)
      state_r == CMSC_PSEUDO_STOP);
   c_exit_latency: cover property (@(posedge clk) disable iff (!rst_n)
      state_r == CMSC_EXIT_LAT ##1 state_r == CMSC_RUN);
   c_bypass: cover property (@(posedge clk) disable iff (!rst_n)
      clk_mode == CMSC_PLL_BYPASS);

endmodule // cmsc_ctrl

// [cmsc_src_model.sv]
// clock source and crystal model for the clock mode and stop controller
// assumes the controller's source-on outputs gate the pll, crystal and reference pulse trains; rc_clk always runs
`timescale 1ns/100ps
module cmsc_src_model #(
   parameter int STARTUP = 20
)
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic pll_on,
   input  wire logic ref_on,
   input  wire logic osc_on,
   output logic      pll_out_clk,
   output logic      crystal_clk,
   output logic      internal_ref_clk,
   output logic      rc_clk,
   output logic      osc_up_status,
   output logic      pll_lock
);
   logic [7:0] div_r;
   int         up_r;
   int         lock_r;

   // sources run at different rates (every 2nd, 4th, 8th, 16th cycle) so a wrong selection shows in the pulse pattern
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 8'h00;
         pll_out_clk <= 1'b0;
         crystal_clk <= 1'b0;
         internal_ref_clk <= 1'b0;
         rc_clk <= 1'b0;
      end else begin
         div_r <= div_r + 8'h01;
         pll_out_clk <= pll_on && div_r[0];
         crystal_clk <= osc_on && (div_r[1:0] == 2'h3);
         internal_ref_clk <= ref_on && (div_r[2:0] == 3'h5);
         rc_clk <= (div_r[3:0] == 4'h9);
      end
   end

   // status only rises after a full start-up or lock span, and drops at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         up_r <= 0;
         lock_r <= 0;
         osc_up_status <= 1'b0;
         pll_lock <= 1'b0;
      end else begin
         up_r <= osc_on ? up_r + 1 : 0;
         lock_r <= pll_on ? lock_r + 1 : 0;
         osc_up_status <= osc_on && (up_r >= STARTUP);
         pll_lock <= pll_on && (lock_r >= 6);
      end
   end
endmodule // cmsc_src_model

// [clock_mode_stop_controller_test.sv]
// self-checking bench for the clock mode and stop controller
// assumes cmsc_src_model supplies source pulses and oscillator status
`timescale 1ns/100ps
module clock_mode_stop_controller_test;
   import cmsc_pkg::*;
   localparam int LAT = 4;
   logic clk, arst_n, ext_rst_n, rst_pin_in, rst_pin_out, rst_pin_oe, int_reset_req;
   logic stop_req, wake_req, wait_req, debug_halt_state, pll_select, osc_enable;
   logic pseudo_stop_sel, wdog_src_sel_hi, wdog_src_sel_lo, periodic_src_sel;
   logic wdog_stop_disable, wdog_pseudo_en, periodic_pseudo_en, debug_freeze_timers;
   logic osc_up_status, pll_lock, pll_out_clk, crystal_clk, internal_ref_clk, rc_clk;
   logic bus_clk_en, pll_on, internal_ref_osc, osc_on, pll_ref_ext, regulator_reduced_perf;
   logic low_volt_en, autonomous_periodic_timer, wdog_tick, periodic_tick, latency_busy;
   logic [2:0]     wdog_rate, wdog_rate_eff;
   logic [4:0]     pll_post_div;
   logic [7:0]     vco_target_mhz;
   cmsc_clk_mode_t clk_mode;
   cmsc_state_t    stop_state;
   int             n_errors, n_tests, nb, nw, np;

   // open-drain pin with pull-up: low if either party pulls it
   assign rst_pin_in = ext_rst_n & ~(rst_pin_oe & ~rst_pin_out);

   cmsc_ctrl #(.LATENCY_CYC(LAT)) i_cmsc_ctrl (.*);

   cmsc_src_model i_cmsc_src_model (.clk(clk), .arst_n(arst_n), .pll_on(pll_on),
      .ref_on(internal_ref_osc), .osc_on(osc_on), .pll_out_clk(pll_out_clk),
      .crystal_clk(crystal_clk), .internal_ref_clk(internal_ref_clk), .rc_clk(rc_clk),
      .osc_up_status(osc_up_status), .pll_lock(pll_lock));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // stop or wake request held over exactly one taking edge
   task req(input logic wake);
      @(posedge clk);
      if (wake)
         wake_req <= 1'b1;
      else
         stop_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      stop_req <= 1'b0;
      #1;
   endtask

   task count(input int n);
      nb = 0;
      nw = 0;
      np = 0;
      repeat (n) begin
         tick(1);
         nb += (bus_clk_en === 1'b1);
         nw += (wdog_tick === 1'b1);
         np += (periodic_tick === 1'b1);
      end
   endtask

   // bus enable repeats the selected source two cycles later (switch and output flops)
   task follow(input logic xtal, input int n);
      logic s0, s1;
      s1 = xtal ? crystal_clk : pll_out_clk;
      tick(1);
      repeat (n) begin
         s0 = s1;
         s1 = xtal ? crystal_clk : pll_out_clk;
         tick(1);
         chk({7'h00, bus_clk_en}, {7'h00, s0}); // bus tracks source
      end
   endtask

   task wait_osc;
      for (int i = 0; i < 200 && osc_up_status !== 1'b1; i++)
         tick(1);
   endtask

   initial begin
      #60000;
      n_errors++;
      summarize();
   end

   initial begin
      {arst_n, ext_rst_n, int_reset_req, stop_req, wake_req, wait_req} = 6'h10;
      {debug_halt_state, osc_enable, pseudo_stop_sel, wdog_src_sel_hi} = 4'h0;
      {wdog_src_sel_lo, periodic_src_sel, wdog_stop_disable, wdog_pseudo_en} = 4'h0;
      {periodic_pseudo_en, debug_freeze_timers} = 2'h0;
      ext_rst_n = 1'b1;
      pll_select = 1'b1;
      wdog_rate = 3'h3;
      n_errors = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      tick(2);
      chk({6'h00, clk_mode}, 8'h00); // default internal-ref mode
      chk({3'h0, pll_post_div}, 8'h03); // post divider
      chk(vco_target_mhz, 8'h32); // vco target
      chk({7'h00, pll_ref_ext}, 8'h00); // internal reference
      chk({6'h00, internal_ref_osc, autonomous_periodic_timer}, 8'h03); // reference on
      tick(4);
      follow(1'b0, 20); // bus on pll clock
      // software path to external reference: enable, wait up and lock
      @(posedge clk);
      osc_enable <= 1'b1; // enable oscillator
      for (int i = 0; i < 200 && !(osc_up_status === 1'b1 && pll_lock === 1'b1); i++)
         tick(1); // wait status
      tick(2);
      chk({7'h00, pll_ref_ext}, 8'h01); // external reference
      chk({6'h00, clk_mode}, 8'h01); // external mode
      @(posedge clk);
      pll_select <= 1'b0; // select crystal after up
      tick(12);
      chk({6'h00, clk_mode}, 8'h02); // bypass mode
      chk({7'h00, pll_on}, 8'h01); // pll kept running
      follow(1'b1, 24); // bus on crystal after the switch
      @(posedge clk);
      wait_req <= 1'b1;
      count(16);
      chk({5'h00, stop_state}, 8'h00); // wait equals run
      chk({7'h00, nb != 0}, 8'h01); // bus keeps running
      @(posedge clk);
      wait_req <= 1'b0;
      req(1'b1);
      chk({5'h00, stop_state}, 8'h00); // wake in run ignored
      @(posedge clk);
      {pseudo_stop_sel, wdog_pseudo_en, periodic_pseudo_en} <= 3'h7;
      req(1'b0);
      chk({5'h00, stop_state}, 8'h03); // pseudo stop
      chk({6'h00, pll_on, internal_ref_osc}, 8'h00); // sources off
      chk({6'h00, regulator_reduced_perf, low_volt_en}, 8'h02); // reduced regulator
      chk({7'h00, osc_on}, 8'h01); // oscillator runs
      count(32);
      chk({7'h00, nb != 0}, 8'h00); // bus stopped
      chk({6'h00, nw != 0, np != 0}, 8'h03); // timers on crystal
      req(1'b1);
      chk({5'h00, stop_state}, 8'h00); // wake to run
      tick(2);
      chk({6'h00, clk_mode}, 8'h02); // select unchanged
      @(posedge clk);
      {wdog_pseudo_en, periodic_pseudo_en} <= 2'h0;
      req(1'b0);
      count(32);
      chk({6'h00, nw != 0, np != 0}, 8'h00); // timers need enables
      req(1'b1);
      @(posedge clk);
      pseudo_stop_sel <= 1'b0;
      req(1'b0);
      chk({5'h00, stop_state}, 8'h02); // full stop
      chk({7'h00, osc_on}, 8'h00); // oscillator off
      count(32);
      chk({5'h00, nb != 0, nw != 0, np != 0}, 8'h00); // all halted
      req(1'b1);
      tick(4);
      chk({6'h00, clk_mode}, 8'h00); // wake on pll clock
      @(posedge clk);
      pll_select <= 1'b1;
      tick(8);
      follow(1'b0, 16); // bus on pll
      count(32);
      chk({6'h00, nw != 0, np != 0}, 8'h03); // timers on reference
      chk({nw[3:0], np[3:0]}, 8'h44); // reference rate
      @(posedge clk);
      {wdog_src_sel_lo, periodic_src_sel} <= 2'h3;
      tick(4);
      count(32);
      chk({nw[3:0], np[3:0]}, 8'h88); // crystal when selected
      @(posedge clk);
      {wdog_src_sel_lo, periodic_src_sel} <= 2'h0;
      @(posedge clk);
      wdog_src_sel_hi <= 1'b1;
      req(1'b0);
      chk({5'h00, stop_state}, 8'h02); // no latency when active
      count(40);
      chk({6'h00, nw != 0, np != 0}, 8'h02); // rc watchdog, periodic halted
      req(1'b1);
      @(posedge clk);
      wdog_stop_disable <= 1'b1;
      req(1'b0);
      chk({5'h00, stop_state}, 8'h01); // entry latency
      chk({7'h00, latency_busy}, 8'h01); // latency flag
      tick(LAT - 1);
      chk({5'h00, stop_state}, 8'h01); // latency length
      tick(1);
      chk({5'h00, stop_state}, 8'h02); // latency ends
      count(40);
      chk({7'h00, nw != 0}, 8'h00); // watchdog frozen
      req(1'b1);
      chk({5'h00, stop_state}, 8'h04); // exit latency
      tick(LAT);
      chk({5'h00, stop_state}, 8'h00); // back to run
      @(posedge clk);
      wdog_stop_disable <= 1'b0;
      wait_osc(); // wait start-up before pseudo
      @(posedge clk);
      {pseudo_stop_sel, periodic_pseudo_en} <= 2'h3;
      req(1'b0);
      count(40);
      chk({6'h00, nw != 0, np != 0}, 8'h03); // periodic on crystal
      req(1'b1);
      @(posedge clk);
      {debug_halt_state, debug_freeze_timers} <= 2'h3;
      tick(2);
      count(40);
      chk({5'h00, nb != 0, nw != 0, np != 0}, 8'h04); // timers frozen
      @(posedge clk);
      debug_freeze_timers <= 1'b0;
      tick(3);
      chk({5'h00, wdog_rate_eff}, 8'h07); // longest rate
      @(posedge clk);
      debug_halt_state <= 1'b0;
      tick(3);
      chk({5'h00, wdog_rate_eff}, 8'h03); // normal rate
      count(40);
      chk({7'h00, nw != 0}, 8'h01); // resumes after debug
      @(posedge clk);
      pll_select <= 1'b0;
      int_reset_req <= 1'b1;
      tick(1);
      chk({6'h00, rst_pin_oe, rst_pin_out}, 8'h02); // pin driven low
      tick(1);
      chk({6'h00, clk_mode}, 8'h00); // internal reset via pin
      @(posedge clk);
      int_reset_req <= 1'b0;
      tick(3);
      chk({7'h00, rst_pin_oe}, 8'h00); // pin released
      @(posedge clk);
      pll_select <= 1'b1;
      wdog_src_sel_hi <= 1'b0;
      ext_rst_n <= 1'b0;
      tick(1);
      chk({5'h00, stop_state}, 8'h00); // external reset
      chk({7'h00, bus_clk_en}, 8'h00); // bus held in reset
      @(posedge clk);
      ext_rst_n <= 1'b1;
      tick(8);
      follow(1'b0, 12); // pll mode after reset
      summarize();
   end
endmodule // clock_mode_stop_controller_test
